/* File: logic/frdm_map.vh */
// Summary of operation
// [RQ1] Each channel update is one 24-bit frame; top 8 bits hold address/select/command.
// [RQ2] Low 16 bits of each frame hold the output code in straight binary.
// [RQ3] Filter results are accepted as full-range 16-bit two's complement values.
// [RQ4] DAC code is the signed result plus 32767.
// [RQ5] Every frame uses immediate load; load strobe pin held inactive. The startup reference frame carries command 0 instead.
// [RQ6] At start the DAC is set to its internal 2.5 V reference first.
// [RQ7] This block is serial master, making serial clock and frame timing.
// [RQ8] Overload detection enabled from reset with default thresholds; host may replace.
// [RQ9] On overload a fault record latches and the fault pin goes high.
// [RQ10] Host polls the latched fault record periodically.
// [RQ11] Modulator clock for the link channel is a fixed 5 MHz.
// [RQ12] Clock synthesizer set to 1 MHz after power-up, redone on new settings.
// [RQ13] Comparator uses first-order sinc, ratio 32, 5-bit unsigned thresholds.
// [RQ14] Frames go MSB first; select low for whole frame, high between.
`ifndef FRDM_MAP_VH
`define FRDM_MAP_VH
`define FRDM_FRAME_BITS      24
`define FRDM_CODE_OFFSET     16'h7FFF
`define FRDM_CMD_IMMEDIATE   2'h1
`define FRDM_CMD_REFERENCE   2'h0
`define FRDM_REF_INT_ON      24'h011000
`define FRDM_OSR             32
`define FRDM_THR_HI_DEFAULT  5'h1F
`define FRDM_THR_LO_DEFAULT  5'h01
`define FRDM_CLK_HZ          10000000
`define FRDM_MOD_CLK_HZ      5000000
`define FRDM_SYNTH_HZ        20'hF4240
`define FRDM_SCLK_HALF       1
`endif

/* File: logic/frdm_fifo.v */
`timescale 1ns/10ps
module frdm_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset_n,
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  output wire             out_valid,
  input  wire             out_ready,
  output reg  [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  reg             ov_q;
  wire [AW:0]     count  = wr_q - rd_q;
  wire            full   = (count == DEPTH[AW:0]);
  wire            empty  = (count == {(AW+1){1'b0}});
  wire            pop    = empty ? 1'b0 : (!ov_q || out_ready);
  assign in_ready  = !full;
  assign out_valid = ov_q;
  always @(posedge clk) begin
    if (in_valid && !full)
      mem_q[wr_q[AW-1:0]] <= in_data;
  end
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q     <= {(AW+1){1'b0}};
      rd_q     <= {(AW+1){1'b0}};
      ov_q     <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (in_valid && !full)
        wr_q <= wr_q + 1'b1;
      if (pop) begin
        out_data <= mem_q[rd_q[AW-1:0]];
        rd_q     <= rd_q + 1'b1;
        ov_q     <= 1'b1;
      end else if (out_ready)
        ov_q <= 1'b0;
    end
  end
endmodule

/* File: logic/frdm_spi_tx.v */
`timescale 1ns/10ps
`include "frdm_map.vh"
module frdm_spi_tx #(
  parameter HALF = `FRDM_SCLK_HALF
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        start,
  input  wire [23:0] frame,
  output wire        busy,
  output reg         sclk,
  output reg         sync_n,
  output reg         mosi
);
  reg [23:0] sh_q;
  reg [4:0]  bits_q;
  reg [7:0]  div_q;
  reg        act_q;
  assign busy = act_q;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sh_q <= 24'h000000; bits_q <= 5'h00; div_q <= 8'h00;
      act_q <= 1'b0; sclk <= 1'b1; sync_n <= 1'b1; mosi <= 1'b0;
    end else if (!act_q) begin
      sclk <= 1'b1;
      sync_n <= 1'b1; // RQ14
      if (start) begin
        act_q  <= 1'b1;
        sync_n <= 1'b0; // RQ14
        mosi   <= frame[23]; // RQ14
        sh_q   <= {frame[22:0], 1'b0};
        bits_q <= 5'h18;
        div_q  <= 8'h00;
      end
    end else if (div_q != HALF[7:0] - 8'h01) begin
      div_q <= div_q + 8'h01;
    end else begin
      div_q <= 8'h00;
      sclk  <= ~sclk; // RQ7
      if (sclk == 1'b0) begin
        if (bits_q == 5'h01) begin
          act_q <= 1'b0; sync_n <= 1'b1; // RQ14
        end else begin
          mosi <= sh_q[23];
          sh_q <= {sh_q[22:0], 1'b0};
        end
        bits_q <= bits_q - 5'h01;
      end
    end
  end
endmodule

/* File: logic/frdm_mirror.v */
`timescale 1ns/10ps
`include "frdm_map.vh"
module frdm_mirror #(
  parameter DEPTH = 16,
  parameter [7:0] DAC_ADDR = 8'h00
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        res_valid,
  output wire        res_ready,
  input  wire [15:0] res_data,
  input  wire [1:0]  res_chan,
  input  wire        cmp_bit,
  input  wire        thr_wr,
  input  wire [4:0]  thr_hi,
  input  wire [4:0]  thr_lo,
  input  wire        fault_clr,
  output reg         fault_q,
  output reg         fault_ind_q,
  output wire        dac_sclk,
  output wire        dac_sync_n,
  output wire        dac_mosi,
  output wire        dac_load_strobe_n,
  output reg         mod_clk_q,
  input  wire        synth_new,
  output reg         synth_req_q,
  output reg  [19:0] synth_hz_q
);
  localparam S_RESET = 2'd0;
  localparam S_REF   = 2'd1;
  localparam S_RUN   = 2'd2;
  localparam integer MOD_DIV = `FRDM_CLK_HZ / (2 * `FRDM_MOD_CLK_HZ);
  reg  [1:0]  st_q;
  wire [17:0] f_data;
  wire        f_valid;
  wire        tx_busy;
  reg         start;
  reg  [23:0] frame;
  wire [15:0] code = f_data[15:0] + `FRDM_CODE_OFFSET; // RQ3 RQ4
  assign dac_load_strobe_n = 1'b1; // RQ5
  frdm_fifo #(.WIDTH(18), .DEPTH(DEPTH), .AW(4)) u_fifo (
    .clk       (core_clk),
    .reset_n   (reset_n),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({res_chan, res_data}),
    .out_valid (f_valid),
    .out_ready (start && st_q == S_RUN),
    .out_data  (f_data)
  );
  always @* begin
    start = 1'b0;
    frame = `FRDM_REF_INT_ON;
    case (st_q)
      S_REF: start = !tx_busy; // RQ6
      S_RUN: begin
        start = f_valid && !tx_busy;
        frame = {DAC_ADDR[7:6], `FRDM_CMD_IMMEDIATE, 1'b0,
                 f_data[17:16], 1'b0, code}; // RQ1 RQ2 RQ5
      end
      default: start = 1'b0;
    endcase
  end
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n)
      st_q <= S_RESET;
    else case (st_q)
      S_RESET: st_q <= S_REF;
      S_REF:   if (!tx_busy) st_q <= S_RUN; // RQ6
      default: st_q <= S_RUN;
    endcase
  end
  frdm_spi_tx u_tx (
    .clk     (core_clk),
    .reset_n (reset_n),
    .start   (start),
    .frame   (frame),
    .busy    (tx_busy),
    .sclk    (dac_sclk),
    .sync_n  (dac_sync_n),
    .mosi    (dac_mosi)
  );
  // Comparator: first-order sinc over 32 modulator bits
  reg [4:0] win_q;
  reg [5:0] acc_q;
  reg [4:0] thi_q;
  reg [4:0] tlo_q;
  wire [5:0] sum = acc_q + {5'h00, cmp_bit};
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      win_q <= 5'h00; acc_q <= 6'h00;
      thi_q <= `FRDM_THR_HI_DEFAULT; tlo_q <= `FRDM_THR_LO_DEFAULT; // RQ8
      fault_q <= 1'b0; fault_ind_q <= 1'b0;
    end else begin
      if (thr_wr) begin
        thi_q <= thr_hi; tlo_q <= thr_lo; // RQ8 RQ13
      end
      win_q <= win_q + 5'h01; // RQ13
      if (win_q == 5'h1F) begin
        acc_q <= 6'h00;
        if (sum > {1'b0, thi_q} || sum < {1'b0, tlo_q}) begin
          fault_q <= 1'b1; fault_ind_q <= 1'b1; // RQ9
        end else if (fault_clr) begin
          fault_q <= 1'b0; fault_ind_q <= 1'b0; // RQ10
        end
      end else begin
        acc_q <= sum;
        if (fault_clr) begin
          fault_q <= 1'b0; fault_ind_q <= 1'b0; // RQ10
        end
      end
    end
  end
  // Fixed modulator clock, half of core clock
  reg [3:0] mdiv_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mdiv_q <= 4'h0; mod_clk_q <= 1'b0;
    end else if (mdiv_q == MOD_DIV[3:0] - 4'h1) begin
      mdiv_q <= 4'h0; mod_clk_q <= ~mod_clk_q; // RQ11
    end else
      mdiv_q <= mdiv_q + 4'h1;
  end
  // Synthesizer request: 1 MHz after reset, repeat on new settings
  reg boot_q;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      boot_q <= 1'b0; synth_req_q <= 1'b0; synth_hz_q <= 20'h00000;
    end else begin
      boot_q      <= 1'b1;
      synth_hz_q  <= `FRDM_SYNTH_HZ; // RQ12
      synth_req_q <= !boot_q || synth_new; // RQ12
    end
  end
endmodule

/* File: tb/frdm_checker.sv */
`timescale 1ns/10ps
module frdm_checker (
  input logic        core_clk,
  input logic        reset_n,
  input logic        fault_q,
  input logic        fault_ind_q,
  input logic        dac_sclk,
  input logic        dac_sync_n,
  input logic        dac_mosi,
  input logic        dac_load_strobe_n,
  input logic        mod_clk_q,
  input logic        synth_req_q,
  input logic [19:0] synth_hz_q
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_frame;
    !dac_sync_n throughout (##47 1'b1);
  endsequence
  a_frame_len: assert property ($fell(dac_sync_n) |-> s_frame ##1 dac_sync_n)
    else $error("select time");
  a_sclk_idle: assert property (dac_sync_n |-> dac_sclk)
    else $error("clock idle");
  a_sclk_run: assert property (!dac_sync_n && !$fell(dac_sync_n)
    |-> dac_sclk != $past(dac_sclk)) else $error("clock run");
  a_mosi_hold: assert property (!dac_sync_n && !$rose(dac_sclk)
    && !$fell(dac_sync_n) |-> $stable(dac_mosi)) else $error("data edge");
  a_strobe_off: assert property (dac_load_strobe_n)
    else $error("strobe");
  a_fault_pin: assert property (fault_ind_q == fault_q)
    else $error("fault pin");
  a_mod_toggle: assert property (1'b1 |=> mod_clk_q != $past(mod_clk_q))
    else $error("mod clock");
  a_synth_req: assert property (synth_req_q
    |-> synth_hz_q == 20'hF4240 ##1 !synth_req_q) else $error("synth");
endmodule
bind frdm_mirror frdm_checker frdm_checker_inst (.core_clk, .reset_n,
  .fault_q, .fault_ind_q, .dac_sclk, .dac_sync_n, .dac_mosi,
  .dac_load_strobe_n, .mod_clk_q, .synth_req_q, .synth_hz_q);

/* File: tb/frdm_dac_model.sv */
`timescale 1ns/10ps
module frdm_dac_model (
  input logic dac_sclk,
  input logic dac_sync_n,
  input logic dac_mosi
);
  logic [23:0] sh = 24'h0;
  int          n = 0;
  int          bad = 0;
  logic [23:0] q[$];
  always @(negedge dac_sclk) if (!dac_sync_n) begin
    sh <= {sh[22:0], dac_mosi};
    n <= n + 1;
  end
  always @(posedge dac_sync_n) begin
    if (n == 24) q.push_back(sh);
    else if (n != 0) bad++;
    n <= 0;
  end
endmodule

/* File: tb/tb_filter_result_dac_mirror.sv */
`timescale 1ns/10ps
module tb_filter_result_dac_mirror;
  logic        core_clk = 0;
  logic        reset_n = 0;
  logic        res_valid = 0;
  logic [15:0] res_data = 16'h0;
  logic [1:0]  res_chan = 2'h0;
  logic        cmp_bit = 0;
  logic        cmp_one = 0;
  logic        thr_wr = 0;
  logic [4:0]  thr_hi = 5'h1F;
  logic [4:0]  thr_lo = 5'h01;
  logic        fault_clr = 0;
  logic        synth_new = 0;
  logic        res_ready, fault_q, fault_ind_q, dac_sclk, dac_sync_n, dac_mosi;
  int          num_errors = 0;
  int          compares = 0;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cmp_bit <= cmp_one | ~cmp_bit;
  frdm_mirror frdm_mirror_inst (.core_clk, .reset_n, .res_valid, .res_ready,
    .res_data, .res_chan, .cmp_bit, .thr_wr, .thr_hi, .thr_lo,
    .fault_clr, .fault_q, .fault_ind_q, .dac_sclk, .dac_sync_n, .dac_mosi,
    .dac_load_strobe_n(), .mod_clk_q(), .synth_new, .synth_req_q(),
    .synth_hz_q());
  frdm_dac_model frdm_dac_model_inst (.dac_sclk, .dac_sync_n, .dac_mosi);
  task chk(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task t_stream;
    logic [15:0] d;
    logic        ok;
    int          full;
    full = 0;
    for (int i = 0; i < 20; i++) begin
      res_valid <= 1;
      res_data <= 16'h8000 + i * 16'h0F0F;
      res_chan <= i[1:0];
      do begin
        @(negedge core_clk);
        ok = res_ready;
        full += !ok;
        @(posedge core_clk);
      end while (!ok);
    end
    res_valid <= 0;
    chk(full > 0, 24'h1);
    for (int i = 0; i < 2000 && frdm_dac_model_inst.q.size() < 21; i++)
      @(posedge core_clk);
    chk(frdm_dac_model_inst.q[0], 24'h011000);
    for (int i = 0; i < 20; i++) begin
      d = 16'h8000 + i * 16'h0F0F;
      chk(frdm_dac_model_inst.q[i+1], {5'h02, i[1:0], 1'b0, d + 16'h7FFF});
    end
    chk(frdm_dac_model_inst.bad, 24'h0);
  endtask
  task t_fault;
    chk(fault_q, 24'h0);
    cmp_one <= 1;
    synth_new <= 1;
    @(posedge core_clk);
    synth_new <= 0;
    repeat (70) @(posedge core_clk);
    chk({fault_q, fault_ind_q}, 24'h3);
    cmp_one <= 0;
    repeat (70) @(posedge core_clk);
    fault_clr <= 1;
    @(posedge core_clk);
    fault_clr <= 0;
    repeat (3) @(posedge core_clk);
    chk(fault_q, 24'h0);
    thr_hi <= 5'h0F;
    thr_wr <= 1;
    @(posedge core_clk);
    thr_wr <= 0;
    repeat (70) @(posedge core_clk);
    chk(fault_q, 24'h1);
    thr_hi <= 5'h1F;
    thr_wr <= 1;
    @(posedge core_clk);
    thr_wr <= 0;
    repeat (70) @(posedge core_clk);
    fault_clr <= 1;
    @(posedge core_clk);
    fault_clr <= 0;
    repeat (3) @(posedge core_clk);
    chk(fault_q, 24'h0);
    thr_lo <= 5'h11;
    thr_wr <= 1;
    @(posedge core_clk);
    thr_wr <= 0;
    repeat (70) @(posedge core_clk);
    chk(fault_q, 24'h1);
  endtask
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1;
    @(posedge core_clk);
    t_stream;
    t_fault;
    stop_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    stop_test;
  end
endmodule
